// ---- core/fwr_defs.vh ----
// Constants for the fault waveform recorder.
// Included by the recorder and its sample FIFO; definitions only.
`ifndef FWR_DEFS_VH
`define FWR_DEFS_VH

`define FWR_SAMPLE_W     16
`define FWR_WORD_W       18
`define FWR_TRIG_BIT     16
`define FWR_FAULT_BIT    17
`define FWR_FIFO_DEPTH   8
`define FWR_FIFO_AW      3

`define FWR_ADDR_W       15
`define FWR_LEN_W        13
`define FWR_SPS          13'd64
`define FWR_SPS_SHIFT    6

// Record-count codes and their record counts / lengths in cycles
`define FWR_CNT_6        2'h0
`define FWR_CNT_12       2'h1
`define FWR_CNT_24       2'h2
`define FWR_CNT_36       2'h3
`define FWR_RECS_6       6'h06
`define FWR_RECS_12      6'h0c
`define FWR_RECS_24      6'h18
`define FWR_RECS_36      6'h24
`define FWR_CYC_6        13'h0048
`define FWR_CYC_12       13'h0024
`define FWR_CYC_24       13'h0012
`define FWR_CYC_36       13'h000c

`define FWR_PRE_MIN      4'h1
`define FWR_PRE_MAX      4'h8
`define FWR_PCT_FULL     7'h64
`define FWR_PCT_HALF     20'h00032

`endif

// ---- core/fwr_fifo.v ----
// Sample FIFO between the front end and the record writer.
// Single clock; valid/ready on both sides, storage in flip-flops.
`timescale 1ns/1ps
`include "fwr_defs.vh"

module fwr_fifo #(
   parameter WIDTH = `FWR_WORD_W,
   parameter DEPTH = `FWR_FIFO_DEPTH,
   parameter AW    = `FWR_FIFO_AW
) (
   input  wire             clock_i,
   input  wire             sys_rst_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      fill;
   wire            push;
   wire            pop;

   assign in_ready_o  = (fill != DEPTH[AW:0]);
   assign out_valid_o = (fill != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill   <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            fill <= fill + 1'b1;
         end else if (pop & ~push) begin
            fill <= fill - 1'b1;
         end
      end
   end
endmodule // fwr_fifo

// ---- core/fwr_recorder.v ----
// Fault waveform recorder: writes sample stream into slotted record memory.
// Assumes samples arrive synchronous to clock_i with trigger and fault flags
// aligned to each sample, and a record memory that takes one write per cycle.
`timescale 1ns/1ps
`include "fwr_defs.vh"

// Notes on behaviour
// - Keep at most the configured record count
// - When full, overwrite the oldest record
// - Length 72/36/18/12 cycles per count setting
// - Pre-trigger cycles settable 1 to 8
// - Post-trigger data fills rest of record
// - Split percentage 0 to 100
// - Split applies to post-trigger part only
// - Pre-trigger count independent of split
// - Long fault: split share from end
// - Short fault: contiguous record, no split
// - 64 samples per cycle
module fwr_recorder (
   input  wire                     clock_i,
   input  wire                     sys_rst_i,
   input  wire [1:0]               record_count_setting_i,
   input  wire [3:0]               pretrigger_cycles_i,
   input  wire [6:0]               split_percent_i,
   input  wire [`FWR_SAMPLE_W-1:0] sample_data_i,
   input  wire                     sample_valid_i,
   output wire                     sample_ready_o,
   input  wire                     event_trigger_i,
   input  wire                     fault_active_i,
   input  wire                     mem_ready_i,
   output reg                      mem_we_o,
   output reg  [`FWR_ADDR_W-1:0]   mem_addr_o,
   output reg  [`FWR_SAMPLE_W-1:0] mem_data_o,
   output reg                      record_done_o,
   output reg  [5:0]               done_slot_o,
   output reg  [`FWR_LEN_W-1:0]    done_pre_start_o,
   output reg  [`FWR_LEN_W-1:0]    done_tail_start_o,
   output reg                      done_split_o,
   output reg  [5:0]               records_stored_o,
   output wire                     recording_o
);
   localparam ST_PRE  = 1'b0;
   localparam ST_POST = 1'b1;

   // ----------------------------------------------------------------
   // Sample path
   // ----------------------------------------------------------------
   wire [`FWR_WORD_W-1:0] fifo_out;
   wire                   fifo_valid;
   wire                   take;

   fwr_fifo #(
      .WIDTH (`FWR_WORD_W),
      .DEPTH (`FWR_FIFO_DEPTH),
      .AW    (`FWR_FIFO_AW)
   ) u_fifo (
      .clock_i     (clock_i),
      .sys_rst_i   (sys_rst_i),
      .in_data_i   ({fault_active_i, event_trigger_i, sample_data_i}),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (sample_ready_o),
      .out_data_o  (fifo_out),
      .out_valid_o (fifo_valid),
      .out_ready_i (mem_ready_i)
   );

   // A stalled memory stalls the FIFO, which stalls the front end
   assign take = fifo_valid & mem_ready_i;

   // ----------------------------------------------------------------
   // Settings decode
   // ----------------------------------------------------------------
   reg                    state;
   reg [1:0]              cnt_code;
   reg [5:0]              num_recs;
   reg [`FWR_LEN_W-1:0]   rec_cyc;
   reg [3:0]              pre_cyc;
   reg [6:0]              pct;
   reg [`FWR_LEN_W-1:0]   pre_len;
   reg [`FWR_LEN_W-1:0]   post_len;
   reg [`FWR_LEN_W-1:0]   tail_len;
   reg [`FWR_LEN_W-1:0]   head_len;
   reg [19:0]             tail_prod;

   always @* begin
      case (record_count_setting_i)
         `FWR_CNT_6: begin
            num_recs = `FWR_RECS_6;
            rec_cyc  = `FWR_CYC_6;
         end
         `FWR_CNT_12: begin
            num_recs = `FWR_RECS_12;
            rec_cyc  = `FWR_CYC_12;
         end
         `FWR_CNT_24: begin
            num_recs = `FWR_RECS_24;
            rec_cyc  = `FWR_CYC_24;
         end
         default: begin
            num_recs = `FWR_RECS_36;
            rec_cyc  = `FWR_CYC_36;
         end
      endcase
      if (pretrigger_cycles_i < `FWR_PRE_MIN) begin
         pre_cyc = `FWR_PRE_MIN;
      end else if (pretrigger_cycles_i > `FWR_PRE_MAX) begin
         pre_cyc = `FWR_PRE_MAX;
      end else begin
         pre_cyc = pretrigger_cycles_i;
      end
      pct = (split_percent_i > `FWR_PCT_FULL) ? `FWR_PCT_FULL : split_percent_i;
      pre_len  = {{(`FWR_LEN_W-4){1'b0}}, pre_cyc} << `FWR_SPS_SHIFT;
      post_len = (rec_cyc << `FWR_SPS_SHIFT) - pre_len;
      // End share rounded, from post part only
      tail_prod = ({7'h00, post_len} * {13'h0000, pct} + `FWR_PCT_HALF) / {13'h0000, `FWR_PCT_FULL};
      tail_len  = tail_prod[`FWR_LEN_W-1:0];
      head_len  = post_len - tail_len;
   end

   // ----------------------------------------------------------------
   // Record writer
   // ----------------------------------------------------------------
   reg [5:0]            slot;
   reg [`FWR_LEN_W-1:0] pre_idx;
   reg [`FWR_LEN_W-1:0] post_n;
   reg [`FWR_LEN_W-1:0] tail_idx;
   reg                  wrapped;
   reg [`FWR_LEN_W-1:0] l_pre;
   reg [`FWR_LEN_W-1:0] l_post;
   reg [`FWR_LEN_W-1:0] l_head;
   reg [`FWR_LEN_W-1:0] l_tail;
   reg [`FWR_LEN_W-1:0] l_rlen;
   reg [`FWR_LEN_W-1:0] l_tstart;
   reg [1:0]            seen_code;
   reg [`FWR_LEN_W-1:0] offset;
   reg [`FWR_LEN_W-1:0] next_post_n;
   reg [`FWR_LEN_W-1:0] next_tail_idx;
   reg                  finish;
   wire                 trig;
   wire                 fault;
   wire [20:0]          base_full;
   wire                 over_len;

   assign trig        = fifo_out[`FWR_TRIG_BIT];
   assign fault       = fifo_out[`FWR_FAULT_BIT];
   assign recording_o = (state == ST_POST);
   assign base_full   = {15'h0000, slot} * {8'h00, l_rlen};
   // A sample past the post length can only land on the tail ring
   assign over_len    = (post_n == l_post);

   always @* begin
      next_post_n   = post_n;
      next_tail_idx = tail_idx;
      offset        = pre_idx;
      finish        = 1'b0;
      // The trigger sample is post sample zero, so it lands at offset pre
      if ((state == ST_POST) || trig) begin
         // Head then tail are contiguous until the tail ring wraps
         if (post_n < l_head) begin
            offset = l_pre + post_n;
         end else begin
            offset        = l_pre + l_head + tail_idx;
            next_tail_idx = (tail_idx + 1'b1 == l_tail) ? {`FWR_LEN_W{1'b0}} : tail_idx + 1'b1;
         end
         next_post_n = (post_n == l_post) ? post_n : post_n + 1'b1;
         // With no tail room a long fault simply stops at full length
         finish = (next_post_n == l_post) & (~fault | (l_tail == {`FWR_LEN_W{1'b0}}));
      end
   end

   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state             <= ST_PRE;
         slot              <= 6'h00;
         pre_idx           <= {`FWR_LEN_W{1'b0}};
         post_n            <= {`FWR_LEN_W{1'b0}};
         tail_idx          <= {`FWR_LEN_W{1'b0}};
         wrapped           <= 1'b0;
         l_pre             <= `FWR_SPS;
         l_post            <= `FWR_SPS;
         l_head            <= {`FWR_LEN_W{1'b0}};
         l_tail            <= {`FWR_LEN_W{1'b0}};
         l_rlen            <= `FWR_SPS;
         l_tstart          <= {`FWR_LEN_W{1'b0}};
         seen_code         <= `FWR_CNT_6;
         cnt_code          <= `FWR_CNT_6;
         records_stored_o  <= 6'h00;
         mem_we_o          <= 1'b0;
         mem_addr_o        <= {`FWR_ADDR_W{1'b0}};
         mem_data_o        <= {`FWR_SAMPLE_W{1'b0}};
         record_done_o     <= 1'b0;
         done_slot_o       <= 6'h00;
         done_pre_start_o  <= {`FWR_LEN_W{1'b0}};
         done_tail_start_o <= {`FWR_LEN_W{1'b0}};
         done_split_o      <= 1'b0;
      end else begin
         mem_we_o      <= take;
         record_done_o <= 1'b0;
         if (take) begin
            mem_addr_o <= base_full[`FWR_ADDR_W-1:0] + {2'b00, offset};
            mem_data_o <= fifo_out[`FWR_SAMPLE_W-1:0];
         end
         cnt_code <= record_count_setting_i;
         case (state)
            ST_PRE: begin
               // Pre length latched apart from split
               l_pre  <= pre_len;
               l_post <= post_len;
               l_head <= head_len;
               l_tail <= tail_len;
               l_rlen <= rec_cyc << `FWR_SPS_SHIFT;
               // Memory layout changes with the count, so old records are dropped
               if (cnt_code != seen_code) begin
                  seen_code        <= cnt_code;
                  slot             <= 6'h00;
                  records_stored_o <= 6'h00;
                  pre_idx          <= {`FWR_LEN_W{1'b0}};
               end else if (take) begin
                  if (trig) begin
                     state    <= ST_POST;
                     l_tstart <= pre_idx;
                     post_n   <= next_post_n;
                     tail_idx <= next_tail_idx;
                     wrapped  <= 1'b0;
                  end else begin
                     pre_idx <= (pre_idx + 1'b1 >= l_pre) ? {`FWR_LEN_W{1'b0}} : pre_idx + 1'b1;
                  end
               end
            end
            ST_POST: begin
               if (take) begin
                  post_n   <= next_post_n;
                  tail_idx <= next_tail_idx;
                  // Tail ring overwrote its oldest samples
                  if (over_len) begin
                     wrapped <= 1'b1;
                  end
                  if (finish) begin
                     state             <= ST_PRE;
                     pre_idx           <= {`FWR_LEN_W{1'b0}};
                     post_n            <= {`FWR_LEN_W{1'b0}};
                     tail_idx          <= {`FWR_LEN_W{1'b0}};
                     record_done_o     <= 1'b1;
                     done_slot_o       <= slot;
                     done_pre_start_o  <= l_tstart;
                     done_tail_start_o <= (wrapped | over_len) ? next_tail_idx : {`FWR_LEN_W{1'b0}};
                     done_split_o      <= wrapped | over_len;
                     slot <= (slot + 1'b1 == num_recs) ? 6'h00 : slot + 1'b1;
                     if (records_stored_o != num_recs) begin
                        records_stored_o <= records_stored_o + 1'b1;
                     end
                  end
               end
            end
            default: begin
               state <= ST_PRE;
            end
         endcase
      end
   end
endmodule // fwr_recorder

// ---- sim/fwr_recorder_props.sv ----
// Port checker for the fault waveform recorder, bound to every instance.
// Assumes the settings stay steady while a record closes.
`timescale 1ns/1ps
module fwr_recorder_props (
   input wire        clock_i,
   input wire        sys_rst_i,
   input wire [1:0]  record_count_setting_i,
   input wire [3:0]  pretrigger_cycles_i,
   input wire [6:0]  split_percent_i,
   input wire        mem_ready_i,
   input wire        sample_ready_o,
   input wire        mem_we_o,
   input wire [14:0] mem_addr_o,
   input wire        record_done_o,
   input wire [5:0]  done_slot_o,
   input wire [12:0] done_pre_start_o,
   input wire [12:0] done_tail_start_o,
   input wire        done_split_o,
   input wire [5:0]  records_stored_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   function automatic [5:0] recs(input [1:0] c);
      recs = (c == 2'h0) ? 6'h06 : (c == 2'h1) ? 6'h0c : (c == 2'h2) ? 6'h18 : 6'h24;
   endfunction
   // ----------
   // Properties
   // ----------
   we_ready_a: assert property (mem_we_o |-> $past(mem_ready_i))
      else $error("write while memory stalled");
   stored_cap_a: assert property (records_stored_o <= 6'h24)
      else $error("too many records held");
   stored_step_a: assert property ($changed(records_stored_o) |->
      records_stored_o == $past(records_stored_o) + 6'h01 || records_stored_o == 6'h00)
      else $error("record count jumped");
   slot_range_a: assert property (record_done_o |-> done_slot_o < recs(record_count_setting_i))
      else $error("slot beyond record count");
   // Every count setting shares the same 432 cycles of memory
   addr_span_a: assert property (mem_we_o |-> mem_addr_o < 15'h6c00)
      else $error("write outside record memory");
   pre_start_a: assert property (record_done_o |-> done_pre_start_o < {pretrigger_cycles_i, 6'h00})
      else $error("pre ring start out of range");
   tail_clear_a: assert property (record_done_o && !done_split_o |-> done_tail_start_o == 13'h0000)
      else $error("tail start set on unsplit record");
   split_share_a: assert property (record_done_o && done_split_o |-> split_percent_i != 7'h00)
      else $error("split without tail share");
   done_write_a: assert property (record_done_o |-> mem_we_o)
      else $error("close without last write");
   done_single_a: assert property (record_done_o |=> !record_done_o [*8])
      else $error("close pulse too long");
   cover property (record_done_o && done_split_o);
   cover property (record_done_o && records_stored_o == 6'h24);
   cover property (!sample_ready_o);
endmodule // fwr_recorder_props

bind fwr_recorder fwr_recorder_props i_fwr_recorder_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
   .record_count_setting_i(record_count_setting_i), .pretrigger_cycles_i(pretrigger_cycles_i),
   .split_percent_i(split_percent_i), .mem_ready_i(mem_ready_i), .sample_ready_o(sample_ready_o),
   .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .record_done_o(record_done_o), .done_slot_o(done_slot_o),
   .done_pre_start_o(done_pre_start_o), .done_tail_start_o(done_tail_start_o), .done_split_o(done_split_o),
   .records_stored_o(records_stored_o));

// ---- sim/fwr_mem_model.sv ----
// Record memory model: keeps every write for later inspection.
// Assumes writes are qualified by mem_we_i at the rising edge.
`timescale 1ns/1ps
module fwr_mem_model (
   input  wire        clock_i,
   input  wire        stall_i,
   input  wire        mem_we_i,
   input  wire [14:0] mem_addr_i,
   input  wire [15:0] mem_data_i,
   output wire        mem_ready_o
);
   reg [15:0] mem [0:32767];
   // ---------------
   // Storage
   // ---------------
   // Ready follows the stall request at once, so slow phases start cleanly
   assign mem_ready_o = !stall_i;
   always @(posedge clock_i) begin
      if (mem_we_i) begin
         mem[mem_addr_i] <= mem_data_i;
      end
   end
endmodule // fwr_mem_model

// ---- sim/tb.sv ----
// Testbench: corner and random records through the recorder.
// Assumes the memory model and checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(a, e, m) begin samples_checked = samples_checked + 1; if ((a) !== (e)) begin \
   fail_count = fail_count + 1; $display("MISMATCH %0t %s", $time, m); end end
module tb;
   reg         clock_i = 1'b0;
   reg         sys_rst_i = 1'b1;
   reg  [1:0]  cnt = 2'h3;
   reg  [3:0]  pre = 4'h1;
   reg  [6:0]  pct = 7'h00;
   reg  [15:0] sd = 16'h0000;
   reg         sv = 1'b0, st = 1'b0, sf = 1'b0, stall = 1'b0, slow = 1'b0;
   reg  [5:0]  cyc = 6'h00;
   reg  [31:0] rng = 32'd37;
   wire        rdy, mrdy, we, done, dsplit, rec;
   wire [14:0] addr;
   wire [15:0] wd;
   wire [5:0]  dslot, nst;
   wire [12:0] dpre;
   integer     fail_count = 0, samples_checked = 0;
   integer     npost = 0, ndone = 0, tbase = 0, dones = 0, slot = 0, held = 0, j;
   always #25 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= #1 cyc + 6'h01;
   fwr_recorder i_fwr_recorder (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .record_count_setting_i(cnt),
      .pretrigger_cycles_i(pre), .split_percent_i(pct), .sample_data_i(sd), .sample_valid_i(sv),
      .sample_ready_o(rdy), .event_trigger_i(st), .fault_active_i(sf), .mem_ready_i(mrdy), .mem_we_o(we),
      .mem_addr_o(addr), .mem_data_o(wd), .record_done_o(done), .done_slot_o(dslot), .done_pre_start_o(dpre),
      .done_tail_start_o(), .done_split_o(dsplit), .records_stored_o(nst), .recording_o(rec));
   fwr_mem_model i_fwr_mem_model (.clock_i(clock_i), .stall_i(stall | (slow & (cyc[5:3] == 3'h5))),
      .mem_we_i(we), .mem_addr_i(addr), .mem_data_i(wd), .mem_ready_o(mrdy));
   // ---------------
   // Helpers
   // ---------------
   // Post-trigger words carry bit 15 and their index, so writes are counted
   always @(posedge clock_i) begin : watch
      integer n;
      if (we && wd[15]) begin
         n = (wd[14:0] == 15'h0000) ? 1 : npost + 1;
         npost <= n;
         if (wd[14:0] == 15'h0000) tbase <= addr;
         if (done) ndone <= n;
      end
      if (done) dones <= dones + 1;
      // Recording is up when the trigger write shows and down when the record closes
      if (done || (we && wd == 16'h8000)) `CHK(rec, !done, "recording flag")
   end
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function integer rlen(input [1:0] c);
      rlen = 64 * ((c == 2'h0) ? 72 : (c == 2'h1) ? 36 : (c == 2'h2) ? 18 : 12);
   endfunction
   function integer nrec(input [1:0] c);
      nrec = (c == 2'h0) ? 6 : (c == 2'h1) ? 12 : (c == 2'h2) ? 24 : 36;
   endfunction
   task send(input trig, input flt, input [15:0] d);
      begin
         sv = 1'b1; st = trig; sf = flt; sd = d;
         @(posedge clock_i);
         while (!rdy) @(posedge clock_i);
         #1;
         rng = xs(rng);
         if (rng[2:0] == 3'h0) begin
            sv = 1'b0;
            @(posedge clock_i);
            #1;
         end
      end
   endtask
   task run_rec(input [1:0] c, input [3:0] p, input [6:0] s, input integer flen);
      integer i, k, post, tail, head, en, d0;
      begin
         if (c != cnt) begin
            slot = 0;
            held = 0;
         end
         cnt = c; pre = p; pct = s;
         rng = xs(rng);
         for (i = 0; i < p * 64 + rng[5:0] + 1; i = i + 1) send(1'b0, 1'b0, {1'b0, i[14:0]});
         d0 = dones;
         for (k = 0; dones == d0 && k < 9000; k = k + 1) send(k == 0, k < flen, {1'b1, k[14:0]});
         sv = 1'b0;
         repeat (2) @(posedge clock_i);
         #1;
         post = rlen(c) - p * 64;
         tail = (post * s + 50) / 100;
         head = post - tail;
         en = (flen >= post && tail > 0) ? flen + 1 : post;
         held = (held < nrec(c)) ? held + 1 : held;
         `CHK(ndone, en, "record length")
         `CHK(tbase, slot * rlen(c) + p * 64, "trigger address")
         `CHK(i_fwr_mem_model.mem[slot * rlen(c) + dpre], i - p * 64, "oldest pre sample")
         `CHK(dslot, slot, "slot")
         `CHK(nst, held, "records held")
         `CHK(dsplit, en > post, "split flag")
         `CHK(i_fwr_recorder.done_tail_start_o, (en > post) ? (en - head) % tail : 0, "tail start")
         if (en > post) `CHK(i_fwr_mem_model.mem[tbase + head + (en - 1 - head) % tail], en + 32767, "tail")
         else `CHK(i_fwr_mem_model.mem[tbase + post - 1], post + 32767, "last sample")
         if (head > 0) `CHK(i_fwr_mem_model.mem[tbase + head - 1], head + 32767, "head end")
         slot = (slot + 1) % nrec(c);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Longest expected run is near 70000 cycles
   initial begin
      #(50 * 120000);
      fail_count = fail_count + 1;
      conclude;
   end
   initial begin
      repeat (16) @(posedge clock_i);
      #1 sys_rst_i = 1'b0;
      stall = 1'b1;
      sv = 1'b1;
      repeat (12) @(posedge clock_i);
      #1;
      `CHK(rdy, 1'b0, "fifo refuses when full")
      stall = 1'b0;
      sv = 1'b0;
      run_rec(2'h3, 4'h8, 7'h64, 2000);
      run_rec(2'h3, 4'h1, 7'h00, 2000);
      run_rec(2'h3, 4'h4, 7'h32, 512);
      run_rec(2'h3, 4'h2, 7'h1e, 100);
      slow = 1'b1;
      for (j = 0; j < 36; j = j + 1) begin
         rng = xs(rng);
         run_rec(2'h3, {1'b0, rng[2:0]} + 4'h1, rng[15:8] % 101, rng[27:18]);
      end
      for (j = 0; j < 3; j = j + 1) begin
         run_rec(j[1:0], 4'h3, 7'h19, 300);
         run_rec(j[1:0], 4'h3, 7'h19, 5000);
      end
      conclude;
   end
endmodule // tb
